// file: include/timer8_pkg.sv
// constants, field layouts and types of the 8-bit timer/counter
package timer8_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 3;
   // register offsets
   localparam logic [2:0] OFS_CONTROL_A = 3'h0;
   localparam logic [2:0] OFS_CONTROL_B = 3'h1;
   localparam logic [2:0] OFS_COUNTER = 3'h2;
   localparam logic [2:0] OFS_COMPARE_A = 3'h3;
   localparam logic [2:0] OFS_COMPARE_B = 3'h4;
   localparam logic [2:0] OFS_FLAGS = 3'h5;
   localparam logic [2:0] OFS_MASK = 3'h6;
   localparam logic [2:0] OFS_POWER = 3'h7;
   // control A field positions
   localparam int CA_COMA_LSB = 6;
   localparam int CA_COMB_LSB = 4;
   localparam int CA_WGM_LSB = 0;
   // control B field positions
   localparam int CB_FORCE_A = 7;
   localparam int CB_FORCE_B = 6;
   localparam int CB_WGM2 = 3;
   localparam int CB_CS_LSB = 0;
   // flag and mask bit positions
   localparam int FLAG_OVF = 0;
   localparam int FLAG_CMPA = 1;
   localparam int FLAG_CMPB = 2;
   // values
   localparam logic [7:0] BOTTOM_VALUE = 8'h00;
   localparam logic [7:0] MAX_VALUE = 8'hff;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   // waveform modes
   localparam logic [2:0] WGM_NORMAL = 3'h0;
   localparam logic [2:0] WGM_PHASE_MAX = 3'h1;
   localparam logic [2:0] WGM_CTC = 3'h2;
   localparam logic [2:0] WGM_FAST_MAX = 3'h3;
   localparam logic [2:0] WGM_PHASE_CMPA = 3'h5;
   localparam logic [2:0] WGM_FAST_CMPA = 3'h7;
   // clock source select codes
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   localparam int PRESCALE_W = 10;
   // compare output mode codes
   localparam logic [1:0] COM_OFF = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR = 2'h2;
   localparam logic [1:0] COM_SET = 2'h3;

   typedef struct packed {
      logic [1:0] comA;
      logic [1:0] comB;
      logic [2:0] wgm;
      logic [2:0] cs;
   } timer_cfg_t;

   typedef struct packed {
      logic cmpB;
      logic cmpA;
      logic ovf;
   } timer_evt_t;
endpackage

// file: rtl/timer8_counter_compare.sv
// 8-bit timer/counter with two compare units and waveform outputs
`timescale 1ns/1ps
`default_nettype none
module timer8_counter_compare
   import timer8_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [DATA_W-1:0] regRdData,
   input wire logic externalCountPin,
   input wire logic [2:0] intAck,
   output logic [2:0] intReq,
   output logic compareAOutput,
   output logic compareAEnable,
   output logic compareBOutput,
   output logic compareBEnable
);
   timer_cfg_t cfg_r;
   logic powerReduction_r;
   logic [DATA_W-1:0] counterValue_r;
   logic [DATA_W-1:0] compareAValue_r;
   logic [DATA_W-1:0] compareBValue_r;
   logic [DATA_W-1:0] compareABuf_r;
   logic [DATA_W-1:0] compareBBuf_r;
   timer_evt_t flags_r;
   timer_evt_t mask_r;
   logic [PRESCALE_W-1:0] prescale_r;
   logic [2:0] pinSync_r;
   logic pinLevel_r;
   logic pinLevelOld_r;
   logic countDown_r;
   logic blockMatch_r;
   logic ocA_r;
   logic ocB_r;
   logic [2:0] intReq_r;
   logic [DATA_W-1:0] rdData_r;

   logic wrCtlA, wrCtlB, wrCnt, wrCmpA, wrCmpB, wrFlags, wrMask, wrPower;
   logic tick, running;
   logic isPwm, isFast, isPhase, topIsCmpA;
   logic [DATA_W-1:0] topValue;
   logic atTop, atBottom, matchA, matchB;
   logic [DATA_W-1:0] counter_nxt;
   logic countDown_nxt;
   logic ovfEvent;
   timer_evt_t flags_nxt;
   logic forceA, forceB;

   // register write decode
   assign wrCtlA = regWrStb && regAddr == OFS_CONTROL_A;
   assign wrCtlB = regWrStb && regAddr == OFS_CONTROL_B;
   assign wrCnt = regWrStb && regAddr == OFS_COUNTER;
   assign wrCmpA = regWrStb && regAddr == OFS_COMPARE_A;
   assign wrCmpB = regWrStb && regAddr == OFS_COMPARE_B;
   assign wrFlags = regWrStb && regAddr == OFS_FLAGS;
   assign wrMask = regWrStb && regAddr == OFS_MASK;
   assign wrPower = regWrStb && regAddr == OFS_POWER;
   assign forceA = wrCtlB && regWrData[CB_FORCE_A];
   assign forceB = wrCtlB && regWrData[CB_FORCE_B];

   // mode decode
   assign isFast = cfg_r.wgm == WGM_FAST_MAX || cfg_r.wgm == WGM_FAST_CMPA;
   assign isPhase = cfg_r.wgm == WGM_PHASE_MAX
      || cfg_r.wgm == WGM_PHASE_CMPA;
   assign isPwm = isFast || isPhase;
   assign topIsCmpA = cfg_r.wgm == WGM_CTC || cfg_r.wgm == WGM_PHASE_CMPA
      || cfg_r.wgm == WGM_FAST_CMPA;
   assign topValue = topIsCmpA ? compareAValue_r : MAX_VALUE;
   assign atTop = counterValue_r == topValue;
   assign atBottom = counterValue_r == BOTTOM_VALUE;
   // comparators run at all times
   assign matchA = counterValue_r == compareAValue_r;
   assign matchB = counterValue_r == compareBValue_r;

   // configuration registers
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cfg_r <= '0;
         powerReduction_r <= 1'b0;
      end else begin
         if (wrCtlA) begin
            cfg_r.comA <= regWrData[CA_COMA_LSB +: 2];
            cfg_r.comB <= regWrData[CA_COMB_LSB +: 2];
            cfg_r.wgm[1:0] <= regWrData[CA_WGM_LSB +: 2];
         end
         if (wrCtlB) begin
            cfg_r.wgm[2] <= regWrData[CB_WGM2];
            cfg_r.cs <= regWrData[CB_CS_LSB +: 3];
         end
         if (wrPower) begin
            powerReduction_r <= regWrData[0];
         end
      end
   end

   // prescaler, free-running while any clock source other than stop is selected
   always_ff @(posedge ref_clk) begin
      if (sys_rst || cfg_r.cs == CS_STOP) begin
         prescale_r <= '0;
      end else begin
         prescale_r <= prescale_r + 1'b1;
      end
   end

   // external pin: three stages, a level counts once stages two and three
   // agree, which also rejects single-cycle glitches
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pinSync_r <= 3'h0;
         pinLevel_r <= 1'b0;
         pinLevelOld_r <= 1'b0;
      end else begin
         pinSync_r <= {pinSync_r[1:0], externalCountPin};
         if (pinSync_r[1] == pinSync_r[2]) begin
            pinLevel_r <= pinSync_r[2];
         end
         pinLevelOld_r <= pinLevel_r;
      end
   end

   // tick selection
   assign running = cfg_r.cs != CS_STOP && !powerReduction_r;
   always_comb begin
      case (cfg_r.cs)
         CS_DIV1: tick = 1'b1;
         CS_DIV8: tick = &prescale_r[2:0];
         CS_DIV64: tick = &prescale_r[5:0];
         CS_DIV256: tick = &prescale_r[7:0];
         CS_DIV1024: tick = &prescale_r[9:0];
         CS_EXT_FALL: tick = pinLevelOld_r && !pinLevel_r;
         CS_EXT_RISE: tick = !pinLevelOld_r && pinLevel_r;
         default: tick = 1'b0;
      endcase
      if (powerReduction_r) begin
         tick = 1'b0;
      end
   end

   // counter sequence per mode
   always_comb begin
      counter_nxt = counterValue_r;
      countDown_nxt = countDown_r;
      ovfEvent = 1'b0;
      if (tick && running) begin
         if (isPhase) begin
            // direction turns at top and bottom; overflow at bottom
            if (!countDown_r && atTop) begin
               countDown_nxt = 1'b1;
               counter_nxt = counterValue_r - 1'b1;
            end else if (countDown_r && atBottom) begin
               countDown_nxt = 1'b0;
               counter_nxt = counterValue_r + 1'b1;
            end else if (countDown_r) begin
               counter_nxt = counterValue_r - 1'b1;
            end else begin
               counter_nxt = counterValue_r + 1'b1;
            end
            if (countDown_r && counterValue_r == BOTTOM_VALUE + 8'h01) begin
               ovfEvent = 1'b1;
            end
         end else if (topIsCmpA && atTop) begin
            counter_nxt = BOTTOM_VALUE;
            // clear-on-compare with top at max still passes ff to zero
            ovfEvent = isFast || counterValue_r == MAX_VALUE;
         end else begin
            counter_nxt = counterValue_r + 1'b1;
            countDown_nxt = 1'b0;
            ovfEvent = counterValue_r == MAX_VALUE;
         end
      end
      if (wrCnt) begin
         counter_nxt = regWrData;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         counterValue_r <= RESET_VALUE;
         countDown_r <= 1'b0;
      end else begin
         counterValue_r <= counter_nxt;
         countDown_r <= countDown_nxt;
      end
   end

   // a counter write blocks matches for the next tick, even when stopped
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         blockMatch_r <= 1'b0;
      end else if (wrCnt) begin
         blockMatch_r <= 1'b1;
      end else if (tick && running) begin
         blockMatch_r <= 1'b0;
      end
   end

   // compare registers with optional double buffer
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         compareAValue_r <= RESET_VALUE;
         compareBValue_r <= RESET_VALUE;
         compareABuf_r <= RESET_VALUE;
         compareBBuf_r <= RESET_VALUE;
      end else begin
         if (wrCmpA) begin
            compareABuf_r <= regWrData;
         end
         if (wrCmpB) begin
            compareBBuf_r <= regWrData;
         end
         if (!isPwm) begin
            // buffer bypassed, writes land at once
            if (wrCmpA) begin
               compareAValue_r <= regWrData;
            end
            if (wrCmpB) begin
               compareBValue_r <= regWrData;
            end
         end else if (tick && running && atTop) begin
            // fast pwm wraps to bottom here, phase pwm turns at top
            compareAValue_r <= compareABuf_r;
            compareBValue_r <= compareBBuf_r;
         end
      end
   end

   // flags: hardware set wins over a clear in the same cycle
   always_comb begin
      flags_nxt = flags_r;
      if (wrFlags) begin
         flags_nxt = flags_nxt & ~timer_evt_t'(regWrData[2:0]);
      end
      flags_nxt = flags_nxt & ~timer_evt_t'(intAck);
      if (ovfEvent) begin
         flags_nxt.ovf = 1'b1;
      end
      if (tick && running && !blockMatch_r && !wrCnt) begin
         // flag lands on the tick after the equality was seen
         if (matchA) begin
            flags_nxt.cmpA = 1'b1;
         end
         if (matchB) begin
            flags_nxt.cmpB = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         flags_r <= '0;
         mask_r <= '0;
      end else begin
         flags_r <= flags_nxt;
         if (wrMask) begin
            mask_r <= timer_evt_t'(regWrData[2:0]);
         end
      end
   end

   // one request line per source, one cycle behind the flags
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         intReq_r <= 3'h0;
      end else begin
         intReq_r <= flags_r & mask_r;
      end
   end

   // waveform generator: com bits act immediately, not double buffered
   function automatic logic waveNext(
      input logic oc,
      input logic [1:0] com,
      input logic match,
      input logic forced,
      input logic isA
   );
      logic res;
      res = oc;
      if (!isPwm) begin
         if (match || forced) begin
            case (com)
               COM_TOGGLE: res = !oc;
               COM_CLEAR: res = 1'b0;
               COM_SET: res = 1'b1;
               default: res = oc;
            endcase
         end
      end else if (isFast) begin
         if (com == COM_TOGGLE && isA && cfg_r.wgm[2] && match) begin
            res = !oc;
         end else if (com[1] && match) begin
            res = com[0];
         end else if (com[1] && atTop) begin
            res = !com[0];
         end
      end else begin
         if (com == COM_TOGGLE && isA && cfg_r.wgm[2] && match) begin
            res = !oc;
         end else if (com[1] && match) begin
            res = com[0] ^ countDown_r;
         end
      end
      return res;
   endfunction

   logic tickMatchA, tickMatchB;
   // output action is blocked exactly like the flags around a counter write
   assign tickMatchA = tick && running && matchA && !blockMatch_r
      && !wrCnt;
   assign tickMatchB = tick && running && matchB && !blockMatch_r
      && !wrCnt;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ocA_r <= 1'b0;
         ocB_r <= 1'b0;
      end else begin
         if ((tick && running) || forceA) begin
            ocA_r <= waveNext(ocA_r, cfg_r.comA, tickMatchA,
               forceA && !isPwm, 1'b1);
         end
         if ((tick && running) || forceB) begin
            ocB_r <= waveNext(ocB_r, cfg_r.comB, tickMatchB,
               forceB && !isPwm, 1'b0);
         end
      end
   end

   // read path: data stand in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rdData_r <= '0;
      end else if (regRdStb) begin
         case (regAddr)
            OFS_CONTROL_A: rdData_r <= {cfg_r.comA, cfg_r.comB, 2'h0,
               cfg_r.wgm[1:0]};
            OFS_CONTROL_B: rdData_r <= {4'h0, cfg_r.wgm[2], cfg_r.cs};
            OFS_COUNTER: rdData_r <= counterValue_r;
            OFS_COMPARE_A: rdData_r <= isPwm ? compareABuf_r
               : compareAValue_r;
            OFS_COMPARE_B: rdData_r <= isPwm ? compareBBuf_r
               : compareBValue_r;
            OFS_FLAGS: rdData_r <= {5'h00, flags_r};
            OFS_MASK: rdData_r <= {5'h00, mask_r};
            OFS_POWER: rdData_r <= {7'h00, powerReduction_r};
            default: rdData_r <= '0;
         endcase
      end else begin
         rdData_r <= '0;
      end
   end

   // pin override stage, kept registered so outputs are clean
   logic outA_r, outB_r, enA_r, enB_r;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         outA_r <= 1'b0;
         outB_r <= 1'b0;
         enA_r <= 1'b0;
         enB_r <= 1'b0;
      end else begin
         outA_r <= ocA_r;
         outB_r <= ocB_r;
         enA_r <= cfg_r.comA != COM_OFF;
         enB_r <= cfg_r.comB != COM_OFF;
      end
   end

   assign regRdData = rdData_r;
   assign intReq = intReq_r;
   assign compareAOutput = outA_r;
   assign compareBOutput = outB_r;
   assign compareAEnable = enA_r;
   assign compareBEnable = enB_r;
endmodule
`default_nettype wire

// file: dv/timer8_checker.sv
// assertion checker bound to the 8-bit timer ports
`timescale 1ns/1ps
`default_nettype none
module timer8_checker
   import timer8_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire logic [DATA_W-1:0] regRdData,
   input wire logic externalCountPin,
   input wire logic [2:0] intAck,
   input wire logic [2:0] intReq,
   input wire logic compareAOutput,
   input wire logic compareAEnable,
   input wire logic compareBOutput,
   input wire logic compareBEnable
);
   logic [7:0] ctlA_r;
   logic [7:0] ctlB_r;
   logic [2:0] mask_r;
   wire logic wrA = regWrStb && regAddr == OFS_CONTROL_A;
   wire logic wrB = regWrStb && regAddr == OFS_CONTROL_B;
   wire logic wrCnt = regWrStb && regAddr == OFS_COUNTER;
   wire logic wrFlg = regWrStb && regAddr == OFS_FLAGS;
   wire logic comANew = regWrData[7:6] != COM_OFF;
   wire logic stopped = ctlB_r[2:0] == CS_STOP;
   // force judged only when the same write stops the timer, so no later match interferes
   wire logic forceA = wrB && regWrData[CB_FORCE_A] &&
      regWrData[3:0] == 4'h0 && !ctlA_r[0] && ctlA_r[7:6] == COM_TOGGLE;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ctlA_r <= 8'h00;
         ctlB_r <= 8'h00;
         mask_r <= 3'h0;
      end else begin
         if (wrA) ctlA_r <= regWrData;
         if (wrB) ctlB_r <= regWrData;
         if (regWrStb && regAddr == OFS_MASK) mask_r <= regWrData[2:0];
      end
   end

   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   rd_idle_a:
   assert property (!$past(regRdStb) |-> regRdData == 8'h00)
      else $error("read data not zero outside read slot");
   reset_out_a:
   assert property ($fell(sys_rst) |-> intReq == 3'h0 && !compareAOutput
      && !compareBOutput && !compareAEnable && !compareBEnable)
      else $error("outputs not cleared by reset");
   cnt_wr_a:
   assert property (wrCnt ##1 (regRdStb && regAddr == OFS_COUNTER)
      |=> regRdData == $past(regWrData, 2))
      else $error("counter write lost");
   mask_gate_a:
   assert property ((intReq & ~$past(mask_r)) == 3'h0)
      else $error("request raised without its mask bit");
   ack_clr_a:
   assert property (intAck[FLAG_OVF] && stopped |-> ##2 !intReq[FLAG_OVF])
      else $error("overflow request not cleared by ack");
   w1c_clr_a:
   assert property (wrFlg && regWrData[FLAG_CMPA] && stopped
      |-> ##2 !intReq[FLAG_CMPA])
      else $error("compare request not cleared by write one");
   force_tgl_a:
   assert property (forceA |-> ##2 compareAOutput != $past(compareAOutput, 2))
      else $error("force strobe did not toggle output");
   enable_a:
   assert property (wrA |-> ##2 compareAEnable == $past(comANew, 2))
      else $error("output enable does not follow mode");

   ovf_c: cover property (intReq[FLAG_OVF]);
   cmpa_c: cover property (intReq[FLAG_CMPA]);
   force_c: cover property (forceA);
endmodule

bind timer8_counter_compare timer8_checker timer8_checker_i (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr),
   .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
   .regRdData(regRdData), .externalCountPin(externalCountPin),
   .intAck(intAck), .intReq(intReq), .compareAOutput(compareAOutput),
   .compareAEnable(compareAEnable), .compareBOutput(compareBOutput),
   .compareBEnable(compareBEnable));
`default_nettype wire

// file: dv/timer8_counter_compare_tb.sv
// self-checking bench for the 8-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module timer8_counter_compare_tb
   import timer8_pkg::*;
;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWrData = 8'h00;
   logic regWrStb = 1'b0;
   logic regRdStb = 1'b0;
   logic [7:0] regRdData;
   logic extPin = 1'b0;
   logic [2:0] intAck = 3'h0;
   logic [2:0] intReq;
   logic oA;
   logic enA;
   logic oB;
   logic enB;
   logic [7:0] rv;
   logic prev;
   logic prevB;
   int miscompares = 0;
   int check_count = 0;

   always #10 ref_clk = ~ref_clk;

   timer8_counter_compare timer8_counter_compare_i (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData), .externalCountPin(extPin), .intAck(intAck),
      .intReq(intReq), .compareAOutput(oA), .compareAEnable(enA),
      .compareBOutput(oB), .compareBEnable(enB));

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask

   // the idle cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge ref_clk);
      regWrStb <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [2:0] a);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge ref_clk);
      regRdStb <= 1'b0;
      #1;
      rv = regRdData;
      @(posedge ref_clk);
   endtask

   // counter write followed at once by its read back
   task automatic wr_rd(input logic [7:0] d);
      regAddr <= OFS_COUNTER;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge ref_clk);
      regWrStb <= 1'b0;
      regRdStb <= 1'b1;
      @(posedge ref_clk);
      regRdStb <= 1'b0;
      #1;
      rv = regRdData;
      @(posedge ref_clk);
      check(rv, d);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic run(input logic [2:0] cs, input int n);
      wr(OFS_CONTROL_B, {5'h00, cs});
      repeat (n) @(posedge ref_clk);
      wr(OFS_CONTROL_B, 8'h00);
   endtask

   task automatic waitReq(input int b);
      int n;
      n = 0;
      while (intReq[b] !== 1'b1 && n < 600) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n >= 600) begin
         miscompares++;
         print_verdict();
      end
   endtask

   task automatic t_reset();
      for (int a = 0; a < 8; a++) begin
         rd(a[2:0]);
         check(rv, 8'h00);
      end
   endtask

   task automatic t_overflow();
      wr(OFS_COMPARE_A, 8'h80);
      wr(OFS_COMPARE_B, 8'h80);
      wr(OFS_MASK, 8'h01);
      wr(OFS_COUNTER, 8'hff);
      tick(20);
      rd(OFS_COUNTER);
      check(rv, 8'hff);
      wr(OFS_CONTROL_B, {5'h00, CS_DIV1});
      waitReq(FLAG_OVF);
      wr(OFS_CONTROL_B, 8'h00);
      rd(OFS_FLAGS);
      check(rv, 8'h01);
      intAck <= 3'h1;
      @(posedge ref_clk);
      intAck <= 3'h0;
      tick(2);
      check({5'h00, intReq}, 8'h00);
   endtask

   task automatic t_ctc();
      wr(OFS_FLAGS, 8'h07);
      wr(OFS_MASK, 8'h02);
      wr(OFS_COMPARE_A, 8'h03);
      wr(OFS_COMPARE_B, 8'h01);
      wr(OFS_CONTROL_A, {COM_TOGGLE, 4'h0, WGM_CTC[1:0]});
      wr(OFS_COUNTER, 8'h00);
      wr(OFS_CONTROL_B, {5'h00, CS_DIV1});
      waitReq(FLAG_CMPA);
      for (int i = 0; i < 6; i++) begin
         rd(OFS_COUNTER);
         check({7'h00, rv > 8'h03}, 8'h00);
      end
      wr_rd(8'h02);
      wr(OFS_CONTROL_B, 8'h00);
      rd(OFS_FLAGS);
      check(rv, 8'h06);
      check({5'h00, intReq}, 8'h02);
      check({7'h00, enA}, 8'h01);
      wr(OFS_FLAGS, 8'h02);
      rd(OFS_FLAGS);
      check(rv, 8'h04);
   endtask

   task automatic t_block();
      wr(OFS_CONTROL_A, 8'h00);
      wr(OFS_FLAGS, 8'h07);
      wr(OFS_COMPARE_A, 8'h05);
      wr(OFS_COUNTER, 8'h05);
      tick(5);
      run(CS_DIV1, 10);
      rd(OFS_FLAGS);
      check(rv, 8'h00);
      wr(OFS_COUNTER, 8'h04);
      run(CS_DIV1, 10);
      rd(OFS_FLAGS);
      check(rv, 8'h02);
   endtask

   task automatic t_buffer();
      wr(OFS_COMPARE_A, 8'h40);
      wr(OFS_CONTROL_A, {6'h00, WGM_FAST_MAX[1:0]});
      wr(OFS_COMPARE_A, 8'h08);
      rd(OFS_COMPARE_A);
      check(rv, 8'h08);
      wr(OFS_FLAGS, 8'h07);
      wr(OFS_COUNTER, 8'h04);
      run(CS_DIV1, 10);
      rd(OFS_FLAGS);
      check(rv, 8'h00);
   endtask

   task automatic t_force();
      wr(OFS_CONTROL_A, {COM_TOGGLE, COM_TOGGLE, 4'h0});
      wr(OFS_FLAGS, 8'h07);
      tick(1);
      prev = oA;
      prevB = oB;
      wr(OFS_CONTROL_B, 8'hc0);
      tick(2);
      check({7'h00, oA}, {7'h00, ~prev});
      check({7'h00, oB}, {7'h00, ~prevB});
      check({7'h00, enB}, 8'h01);
      rd(OFS_FLAGS);
      check(rv, 8'h00);
   endtask

   // the pin filter needs a few cycles, so each level is held for ten
   task automatic pulse(input int n);
      repeat (n) begin
         extPin <= 1'b1;
         repeat (10) @(posedge ref_clk);
         extPin <= 1'b0;
         repeat (10) @(posedge ref_clk);
      end
   endtask

   task automatic t_count();
      wr(OFS_COUNTER, 8'h00);
      wr(OFS_CONTROL_B, {5'h00, CS_EXT_RISE});
      pulse(3);
      wr(OFS_CONTROL_B, {5'h00, CS_EXT_FALL});
      pulse(2);
      wr(OFS_CONTROL_B, 8'h00);
      rd(OFS_COUNTER);
      check(rv, 8'h05);
      wr(OFS_COUNTER, 8'h00);
      run(CS_DIV8, 160);
      rd(OFS_COUNTER);
      check({7'h00, rv inside {[8'h13:8'h15]}}, 8'h01);
      wr(OFS_POWER, 8'h01);
      wr(OFS_COUNTER, 8'h00);
      run(CS_DIV1, 10);
      rd(OFS_COUNTER);
      check(rv, 8'h00);
      wr(OFS_POWER, 8'h00);
   endtask

   // phase pwm with top at compare a: 0..4..0, overflow on the way down
   task automatic t_phase();
      wr(OFS_CONTROL_A, 8'h00);
      wr(OFS_COMPARE_A, 8'h04);
      wr(OFS_CONTROL_A, {6'h00, WGM_PHASE_CMPA[1:0]});
      wr(OFS_FLAGS, 8'h07);
      wr(OFS_MASK, 8'h01);
      wr(OFS_COUNTER, 8'h00);
      wr(OFS_CONTROL_B, {4'h0, WGM_PHASE_CMPA[2], CS_DIV1});
      waitReq(FLAG_OVF);
      wr(OFS_CONTROL_B, {4'h0, WGM_PHASE_CMPA[2], CS_STOP});
      rd(OFS_COUNTER);
      check(rv, 8'h02);
      rd(OFS_FLAGS);
      check(rv, 8'h07);
      rd(OFS_COMPARE_A);
      check(rv, 8'h04);
      wr(OFS_CONTROL_B, 8'h00);
      wr(OFS_CONTROL_A, 8'h00);
   endtask

   initial begin
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      t_reset();
      wr(OFS_POWER, 8'h00);
      t_overflow();
      t_ctc();
      t_block();
      t_buffer();
      t_force();
      t_count();
      t_phase();
      print_verdict();
   end
endmodule
`default_nettype wire
